// ### hw/pvic_pkg.sv
package pvic_pkg;
   // ---------------------------------------------------------------
   // sizes
   // ---------------------------------------------------------------
   localparam int NSRC = 82;
   localparam int SRC_W = 7;
   localparam int BASE_W = 14;
   localparam int VADDR_W = 21;
   localparam int FLO_W = 16;
   localparam int FHI_W = 5;
   localparam int AXI_AW = 8;
   localparam int NPRI_REG = 10;
   localparam int SRC_PER_REG = 8;
   localparam int FIELD_W = 4;
   localparam int FIX_FIRST = 80;
   localparam int EXT_A_SRC = 2;
   localparam int EXT_B_SRC = 3;
   localparam int NPEND = 6;
   localparam int PEND_W = 16;
   localparam int NCFG = 17;
   localparam int NEV = 3;
   // ---------------------------------------------------------------
   // register indices, byte address is index times four
   // ---------------------------------------------------------------
   localparam logic [4:0] IDX_PRI0 = 5'h00;
   localparam logic [4:0] IDX_VBASE = 5'h0A;
   localparam logic [4:0] IDX_FM0 = 5'h0B;
   localparam logic [4:0] IDX_FLO0 = 5'h0C;
   localparam logic [4:0] IDX_FHI0 = 5'h0D;
   localparam logic [4:0] IDX_FM1 = 5'h0E;
   localparam logic [4:0] IDX_FLO1 = 5'h0F;
   localparam logic [4:0] IDX_FHI1 = 5'h10;
   localparam logic [4:0] IDX_PEND0 = 5'h11;
   localparam logic [4:0] IDX_PEND5 = 5'h16;
   localparam logic [4:0] IDX_CTRL = 5'h18;
   localparam logic [4:0] IDX_STAT = 5'h19;
   localparam logic [4:0] IDX_MASK = 5'h1A;
   // ---------------------------------------------------------------
   // field layouts and reset values
   // ---------------------------------------------------------------
   localparam logic [31:0] MSK_PRI = 32'h77777777;
   localparam logic [31:0] MSK_VBASE = 32'h00003FFF;
   localparam logic [31:0] MSK_FM = 32'h0000007F;
   localparam logic [31:0] MSK_FLO = 32'h0000FFFF;
   localparam logic [31:0] MSK_FHI = 32'h0000001F;
   localparam logic [31:0] CFG_RST = 32'h00000000;
   localparam logic [BASE_W-1:0] VBASE_RST = 14'h0000;
   localparam logic [1:0] FIX_LVL = 2'h3;
   localparam logic [1:0] FAST_LVL = 2'h2;
   localparam int CTL_LVL_LO = 2;
   localparam int EV_ACK = 0;
   localparam int EV_FAST = 1;
   localparam int EV_WAKE = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic en;
      logic [1:0] lvl;
   } pvic_pri_s;
   typedef struct packed {
      logic [VADDR_W-1:0] addr;
      logic fast;
      logic [SRC_W-1:0] src;
      logic [1:0] lvl;
   } pvic_vec_s;
endpackage : pvic_pkg

// ### hw/pvic_top.sv
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
module pvic_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [pvic_pkg::AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [pvic_pkg::AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [pvic_pkg::NSRC-1:0] irq_src,
   input wire logic external_request_a_n,
   input wire logic external_request_b_n,
   input wire logic [1:0] core_status_word_mask,
   input wire logic core_ack,
   input wire logic core_return,
   input wire logic low_power,
   output logic core_irq_req,
   output pvic_pkg::pvic_vec_s vector_out,
   output logic boot_addr_drive,
   output logic [1:0] current_level_code,
   output logic wake_req,
   output logic irq
);
   import pvic_pkg::*;

   // ---------------------------------------------------------------
   // register storage
   // ---------------------------------------------------------------
   logic [31:0] cfg_ff [NCFG];
   logic [1:0] ctrl_ff;
   logic [NEV-1:0] stat_ff;
   logic [NEV-1:0] mask_ff;
   logic [3:0] isv_ff;
   logic boot_ff;
   logic [1:0] ext_prev_ff;
   logic [1:0] ext_latch_ff;
   logic [NSRC-1:0] snap_en_ff;
   logic wake_ff;
   logic irq_req_ff;
   pvic_vec_s vec_ff;
   // bus state
   logic aw_have_ff;
   logic w_have_ff;
   logic [AXI_AW-1:0] aw_addr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;

   function automatic logic [31:0] cfg_mask(input int j);
      if (j < NPRI_REG) begin
         return MSK_PRI;
      end
      case (j)
         int'(IDX_VBASE): return MSK_VBASE;
         int'(IDX_FM0), int'(IDX_FM1): return MSK_FM;
         int'(IDX_FLO0), int'(IDX_FLO1): return MSK_FLO;
         default: return MSK_FHI;
      endcase
   endfunction : cfg_mask

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = d[b*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   function automatic logic [SRC_W-1:0] lowest(input logic [NSRC-1:0] v);
      logic [SRC_W-1:0] r;
      r = '0;
      for (int k = NSRC - 1; k >= 0; k--) begin
         if (v[k]) begin
            r = SRC_W'(k);
         end
      end
      return r;
   endfunction : lowest

   function automatic logic mapped(input logic [AXI_AW-1:0] a);
      logic [4:0] ix;
      ix = a[6:2];
      return !a[7] && (ix <= IDX_PEND5 || ix == IDX_CTRL || ix == IDX_STAT || ix == IDX_MASK);
   endfunction : mapped

   // ---------------------------------------------------------------
   // external request lines
   // ---------------------------------------------------------------
   wire [1:0] ext_low = ~{external_request_b_n, external_request_a_n};
   wire [1:0] ext_fall = ext_low & ~ext_prev_ff;
   wire [1:0] edge_sel = ctrl_ff & {2{~low_power}};
   wire [1:0] ext_req = (edge_sel & ext_latch_ff) | (~edge_sel & ext_low);
   wire [1:0] ext_clr = {2{core_ack & ~boot_ff}}
                        & {vec_ff.src == SRC_W'(EXT_B_SRC), vec_ff.src == SRC_W'(EXT_A_SRC)};
   // set wins over the clear from a taken vector
   wire [1:0] nxt_ext_latch = (ext_latch_ff & ~ext_clr) | (ext_fall & ctrl_ff);

   // ---------------------------------------------------------------
   // per source priority and level split
   // ---------------------------------------------------------------
   pvic_pri_s pri [NSRC];
   logic [NSRC-1:0] req;
   logic [NSRC-1:0] src_en;
   logic [NSRC-1:0] lvl_req [4];

   for (genvar i = 0; i < NSRC; i++) begin : g_src
      if (i < FIX_FIRST) begin : g_prog
         assign pri[i] = pvic_pri_s'(cfg_ff[i / SRC_PER_REG][(i % SRC_PER_REG) * FIELD_W +: 3]);
      end else begin : g_fix
         assign pri[i] = '{en: 1'b1, lvl: FIX_LVL};
      end
      if (i == EXT_A_SRC) begin : g_ea
         assign req[i] = ext_req[0];
      end else if (i == EXT_B_SRC) begin : g_eb
         assign req[i] = ext_req[1];
      end else begin : g_plain
         assign req[i] = irq_src[i];
      end
      assign src_en[i] = pri[i].en;
      for (genvar l = 0; l < 4; l++) begin : g_lvl
         assign lvl_req[l][i] = req[i] & pri[i].en & (pri[i].lvl == 2'(l));
      end
   end

   // ---------------------------------------------------------------
   // arbitration
   // ---------------------------------------------------------------
   logic [1:0] win_lvl;
   logic win_any;
   always_comb begin
      win_lvl = 2'h0;
      win_any = 1'b0;
      for (int l = 0; l < 4; l++) begin
         if (|lvl_req[l]) begin
            win_lvl = 2'(l);
            win_any = 1'b1;
         end
      end
   end

   wire [SRC_W-1:0] win_src = lowest(lvl_req[win_lvl]);
   wire [1:0] cur_code = (isv_ff[3] | isv_ff[2]) ? 2'h3 : isv_ff[1] ? 2'h2 :
                         isv_ff[0] ? 2'h1 : 2'h0;
   wire lvl_ok = (win_lvl >= core_status_word_mask)
                 && (win_lvl >= cur_code);
   wire fast0 = (win_lvl == FAST_LVL) && (win_src == cfg_ff[IDX_FM0][SRC_W-1:0]);
   wire fast1 = (win_lvl == FAST_LVL) && (win_src == cfg_ff[IDX_FM1][SRC_W-1:0]);
   wire [BASE_W-1:0] vbase = cfg_ff[IDX_VBASE][BASE_W-1:0];
   wire [VADDR_W-1:0] fast0_addr = {cfg_ff[IDX_FHI0][FHI_W-1:0], cfg_ff[IDX_FLO0][FLO_W-1:0]};
   wire [VADDR_W-1:0] fast1_addr = {cfg_ff[IDX_FHI1][FHI_W-1:0], cfg_ff[IDX_FLO1][FLO_W-1:0]};
   wire [VADDR_W-1:0] sel_addr = boot_ff ? {vbase, SRC_W'(0)} :
                                 fast0 ? fast0_addr :
                                 fast1 ? fast1_addr : {vbase, win_src};
   wire pvic_vec_s nxt_vec = '{addr: sel_addr, fast: ~boot_ff & (fast0 | fast1),
                               src: win_src, lvl: win_lvl};
   wire nxt_irq_req = win_any & lvl_ok & ~boot_ff;
   wire nxt_wake = low_power & |(req & src_en & snap_en_ff);

   // in-service levels: a return retires the highest, a taken vector marks its level
   wire [3:0] ret_clr = ~core_return ? 4'h0 : isv_ff[3] ? 4'h8 : isv_ff[2] ? 4'h4 :
                        isv_ff[1] ? 4'h2 : isv_ff[0] ? 4'h1 : 4'h0;
   wire [3:0] ack_set = (core_ack & ~boot_ff) ? (4'h1 << vec_ff.lvl) : 4'h0;
   wire [3:0] nxt_isv = (isv_ff & ~ret_clr) | ack_set;

   wire [NEV-1:0] ev;
   assign ev[EV_ACK] = core_ack & ~boot_ff;
   assign ev[EV_FAST] = core_ack & ~boot_ff & vec_ff.fast;
   assign ev[EV_WAKE] = nxt_wake & ~wake_ff;

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   wire wr_fire = aw_have_ff & w_have_ff & ~bvalid_ff;
   wire [4:0] wr_idx = aw_addr_ff[6:2];
   wire wr_ok = mapped(aw_addr_ff);
   wire [31:0] wr_word = merge(32'h0, wdata_ff, wstrb_ff);
   wire stat_wr = wr_fire & wr_ok & (wr_idx == IDX_STAT);
   wire [NEV-1:0] nxt_stat = (stat_ff & ~(stat_wr ? wr_word[NEV-1:0] : '0)) | ev;
   wire ar_fire = s_axi_arvalid & ~rvalid_ff;
   wire [4:0] rd_idx = s_axi_araddr[6:2];
   wire [NPEND*PEND_W-1:0] pend_all = {(NPEND*PEND_W - NSRC)'(0), req};
   wire [4:0] pend_k = rd_idx - IDX_PEND0;
   logic [31:0] rd_word;
   always_comb begin
      rd_word = 32'h0;
      if (rd_idx < 5'(NCFG)) begin
         rd_word = cfg_ff[rd_idx];
      end else if (rd_idx <= IDX_PEND5) begin
         rd_word = {16'h0, pend_all[pend_k * PEND_W +: PEND_W]};
      end else if (rd_idx == IDX_CTRL) begin
         rd_word = {28'h0, cur_code, ctrl_ff};
      end else if (rd_idx == IDX_STAT) begin
         rd_word = {(32 - NEV)'(0), stat_ff};
      end else if (rd_idx == IDX_MASK) begin
         rd_word = {(32 - NEV)'(0), mask_ff};
      end
   end

   // ---------------------------------------------------------------
   // bus slave
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_ff <= 1'b0;
         w_have_ff <= 1'b0;
         aw_addr_ff <= '0;
         wdata_ff <= 32'h0;
         wstrb_ff <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0;
         rresp_ff <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_ff <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
         if (ar_fire) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= mapped(s_axi_araddr) ? rd_word : 32'h0;
            rresp_ff <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // configuration registers
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int j = 0; j < NCFG; j++) begin
            cfg_ff[j] <= (j == int'(IDX_VBASE)) ? 32'(VBASE_RST) : CFG_RST;
         end
         ctrl_ff <= 2'h0;
         mask_ff <= '0;
         stat_ff <= '0;
      end else begin
         for (int j = 0; j < NCFG; j++) begin
            if (wr_fire && wr_ok && wr_idx == 5'(j)) begin
               cfg_ff[j] <= merge(cfg_ff[j], wdata_ff, wstrb_ff) & cfg_mask(j);
            end
         end
         if (wr_fire && wr_ok && wr_idx == IDX_CTRL) begin
            ctrl_ff <= merge({30'h0, ctrl_ff}, wdata_ff, wstrb_ff) [CTL_LVL_LO-1:0];
         end
         if (wr_fire && wr_ok && wr_idx == IDX_MASK) begin
            mask_ff <= merge({(32 - NEV)'(0), mask_ff}, wdata_ff, wstrb_ff) [NEV-1:0];
         end
         stat_ff <= nxt_stat;
      end
   end

   // ---------------------------------------------------------------
   // arbiter state and outputs
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         boot_ff <= 1'b1;
         isv_ff <= 4'h0;
         ext_prev_ff <= 2'h0;
         ext_latch_ff <= 2'h0;
         snap_en_ff <= '0;
         wake_ff <= 1'b0;
         irq_req_ff <= 1'b0;
         vec_ff <= '0;
      end else begin
         if (core_ack) begin
            boot_ff <= 1'b0;
         end
         isv_ff <= nxt_isv;
         ext_prev_ff <= ext_low;
         ext_latch_ff <= nxt_ext_latch;
         if (!low_power) begin
            snap_en_ff <= src_en;
         end
         wake_ff <= nxt_wake;
         irq_req_ff <= nxt_irq_req;
         vec_ff <= nxt_vec;
      end
   end

   assign s_axi_awready = ~aw_have_ff & ~bvalid_ff;
   assign s_axi_wready = ~w_have_ff & ~bvalid_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = ~rvalid_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
   assign core_irq_req = irq_req_ff;
   assign vector_out = vec_ff;
   assign boot_addr_drive = boot_ff;
   assign current_level_code = cur_code;
   assign wake_req = wake_ff;
   assign irq = |(stat_ff & mask_ff);
endmodule : pvic_top

// ### bench/pvic_checker.sv
`timescale 1ns/10ps
module pvic_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic [1:0] core_status_word_mask,
   input wire logic core_ack,
   input wire logic core_return,
   input wire logic core_irq_req,
   input pvic_pkg::pvic_vec_s vector_out,
   input wire logic boot_addr_drive,
   input wire logic [1:0] current_level_code
);
   import pvic_pkg::*;
   // ---------------------------------------------------------------
   // bus and arbiter relations
   // ---------------------------------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence s_ar_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_vec_take;
      core_ack && core_irq_req && !core_return;
   endsequence
   property p_read;
      s_ar_take |=> s_axi_rvalid;
   endproperty
   a_read: assert property (p_read) else $error("read answer missing");
   property p_b_stand;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_stand: assert property (p_b_stand) else $error("write answer dropped");
   property p_wr_block;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_wr_block: assert property (p_wr_block) else $error("write taken early");
   property p_boot;
      boot_addr_drive |-> !core_irq_req && vector_out.addr[6:0] == 7'h00;
   endproperty
   a_boot: assert property (p_boot) else $error("boot address wrong");
   property p_mask;
      core_irq_req |-> vector_out.lvl >= $past(core_status_word_mask);
   endproperty
   a_mask: assert property (p_mask) else $error("masked level passed");
   property p_nest;
      core_irq_req |-> vector_out.lvl >= $past(current_level_code);
   endproperty
   a_nest: assert property (p_nest) else $error("nesting level too low");
   property p_normal;
      core_irq_req && !vector_out.fast |-> vector_out.addr[6:0] == vector_out.src;
   endproperty
   a_normal: assert property (p_normal) else $error("vector offset wrong");
   property p_fast;
      core_irq_req && vector_out.fast |-> vector_out.lvl == FAST_LVL;
   endproperty
   a_fast: assert property (p_fast) else $error("fast not level two");
   property p_fixed;
      core_irq_req && vector_out.src >= FIX_FIRST |-> vector_out.lvl == FIX_LVL;
   endproperty
   a_fixed: assert property (p_fixed) else $error("fixed level wrong");
   property p_ack;
      s_vec_take |=> current_level_code >=
         (($past(vector_out.lvl) == 2'h3) ? 2'h3 : $past(vector_out.lvl) + 2'h1);
   endproperty
   a_ack: assert property (p_ack) else $error("level code not raised");
endmodule : pvic_checker

bind pvic_top pvic_checker pvic_checker_i (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .core_status_word_mask(core_status_word_mask), .core_ack(core_ack),
   .core_return(core_return), .core_irq_req(core_irq_req), .vector_out(vector_out),
   .boot_addr_drive(boot_addr_drive), .current_level_code(current_level_code));

// ### bench/pvic_core_model.sv
`timescale 1ns/10ps
module pvic_core_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic core_irq_req,
   input pvic_pkg::pvic_vec_s vector_out,
   input wire logic boot_addr_drive,
   input wire logic ack_en,
   output logic core_ack,
   output pvic_pkg::pvic_vec_s taken_vec
);
   import pvic_pkg::*;
   logic done;
   // boot fetch once, then one vector taken per raise of ack_en
   always @(posedge aclk) begin
      core_ack <= 1'b0;
      if (!aresetn) begin
         done <= 1'b0;
      end else if (core_ack) begin
         taken_vec <= vector_out;
      end else if (boot_addr_drive || (ack_en && core_irq_req && !done)) begin
         core_ack <= 1'b1;
         done <= ack_en;
      end else if (!ack_en) begin
         done <= 1'b0;
      end
   end
endmodule : pvic_core_model

// ### bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   import pvic_pkg::*;
   localparam logic [13:0] VB = 14'h0123;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, core_status_word_mask, current_level_code;
   logic [NSRC-1:0] irq_src;
   logic external_request_a_n, external_request_b_n, core_ack, core_return, low_power;
   logic core_irq_req, boot_addr_drive, wake_req, irq, ack_en;
   pvic_vec_s vector_out, taken_vec;
   int err_total, total_checks;
   pvic_top pvic_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .irq_src(irq_src), .external_request_a_n(external_request_a_n),
      .external_request_b_n(external_request_b_n), .core_status_word_mask(core_status_word_mask),
      .core_ack(core_ack), .core_return(core_return), .low_power(low_power),
      .core_irq_req(core_irq_req), .vector_out(vector_out), .boot_addr_drive(boot_addr_drive),
      .current_level_code(current_level_code), .wake_req(wake_req), .irq(irq));
   pvic_core_model pvic_core_model_i (.aclk(aclk), .aresetn(aresetn), .core_irq_req(core_irq_req),
      .vector_out(vector_out), .boot_addr_drive(boot_addr_drive), .ack_en(ack_en),
      .core_ack(core_ack), .taken_vec(taken_vec));
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic test_done();
      if (err_total == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : test_done
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
      #1;
   endtask : cyc
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      if (n == 50) begin
         err_total++;
         test_done();
      end
      chk("bresp", er, s_axi_bresp);
   endtask : axi_wr
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      if (n == 50) begin
         err_total++;
         test_done();
      end
      chk("rdata", e, s_axi_rdata);
      chk("rresp", er, s_axi_rresp);
   endtask : rdchk
   function automatic logic [20:0] va(input int s);
      return {VB, s[6:0]};
   endfunction : va
   task automatic chkv(input int s, input logic [1:0] l, input logic f, input logic [20:0] a);
      chk("req", 1, core_irq_req);
      chk("vec", {a, f, s[6:0], l}, vector_out);
   endtask : chkv
   // ---------------------------------------------------------------
   // sequence
   // ---------------------------------------------------------------
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {irq_src, core_status_word_mask, core_return, low_power, ack_en} = '0;
      {external_request_a_n, external_request_b_n} = 2'h3;
      s_axi_wstrb = 4'hF;
      aresetn = 1'b0;
      err_total = 0;
      total_checks = 0;
      repeat (15) @(posedge aclk);
      #1;
      chk("boot", 1, boot_addr_drive);
      chk("vec", 0, vector_out);
      @(posedge aclk);
      aresetn <= 1'b1;
      cyc(4);
      chk("boot", 0, boot_addr_drive);
      rdchk(8'h28, 32'h0, RESP_OKAY);
      axi_wr(8'h28, 32'hFFFFC123, RESP_OKAY);
      rdchk(8'h28, {18'h0, VB}, RESP_OKAY);
      axi_wr(8'h5C, 32'h1, RESP_SLVERR);
      rdchk(8'h80, 32'h0, RESP_SLVERR);
      axi_wr(8'h44, 32'hFFFF, RESP_OKAY);
      axi_wr(8'h00, 32'h05500400, RESP_OKAY);
      axi_wr(8'h04, 32'h00000600, RESP_OKAY);
      @(posedge aclk);
      irq_src[6:4] <= 3'h7;
      cyc(3);
      chkv(5, 2'h1, 1'b0, va(5));
      @(posedge aclk);
      irq_src[10] <= 1'b1;
      cyc(3);
      chkv(10, 2'h2, 1'b0, va(10));
      for (int m = 0; m < 4; m++) begin
         @(posedge aclk);
         core_status_word_mask <= m[1:0];
         cyc(3);
         chk("req", 32'(m < 3), core_irq_req);
      end
      @(posedge aclk);
      core_status_word_mask <= 2'h0;
      ack_en <= 1'b1;
      cyc(5);
      chk("taken", {va(10), 1'b0, 7'd10, 2'h2}, taken_vec);
      chk("code", 3, current_level_code);
      chk("req", 0, core_irq_req);
      @(posedge aclk);
      ack_en <= 1'b0;
      irq_src[80] <= 1'b1;
      cyc(3);
      chkv(80, FIX_LVL, 1'b0, va(80));
      @(posedge aclk);
      irq_src[80] <= 1'b0;
      irq_src[6:5] <= 2'h0;
      core_return <= 1'b1;
      @(posedge aclk);
      core_return <= 1'b0;
      cyc(3);
      chk("code", 0, current_level_code);
      axi_wr(8'h2C, 32'd10, RESP_OKAY);
      axi_wr(8'h30, 32'h0000BEEF, RESP_OKAY);
      axi_wr(8'h34, 32'h00000015, RESP_OKAY);
      cyc(3);
      chkv(10, 2'h2, 1'b1, {5'h15, 16'hBEEF});
      axi_wr(8'h04, 32'h00000500, RESP_OKAY);
      cyc(3);
      chkv(10, 2'h1, 1'b0, va(10));
      axi_wr(8'h64, 32'h7, RESP_OKAY);
      axi_wr(8'h68, 32'h1, RESP_OKAY);
      @(posedge aclk);
      ack_en <= 1'b1;
      cyc(5);
      chk("irq", 1, irq);
      rdchk(8'h60, 32'h8, RESP_OKAY);
      axi_wr(8'h68, 32'h0, RESP_OKAY);
      cyc(1);
      chk("irq", 0, irq);
      axi_wr(8'h68, 32'h1, RESP_OKAY);
      axi_wr(8'h64, 32'h1, RESP_OKAY);
      cyc(1);
      chk("irq", 0, irq);
      rdchk(8'h64, 32'h0, RESP_OKAY);
      @(posedge aclk);
      ack_en <= 1'b0;
      irq_src <= '0;
      core_return <= 1'b1;
      @(posedge aclk);
      core_return <= 1'b0;
      axi_wr(8'h60, 32'h1, RESP_OKAY);
      @(posedge aclk);
      external_request_a_n <= 1'b0;
      @(posedge aclk);
      external_request_a_n <= 1'b1;
      cyc(3);
      chkv(2, 2'h0, 1'b0, va(2));
      @(posedge aclk);
      low_power <= 1'b1;
      axi_wr(8'h08, 32'h00040000, RESP_OKAY);
      @(posedge aclk);
      irq_src[20] <= 1'b1;
      cyc(5);
      chk("wake", 0, wake_req);
      @(posedge aclk);
      external_request_a_n <= 1'b0;
      cyc(4);
      chk("wake", 1, wake_req);
      test_done();
   end
endmodule : tb_top
